/* common/hvb_pkg.sv */
// shared constants and types for the hv output word and boost control
package hvb_pkg;
  // serial word layout
  localparam int WORD_W = 24;
  localparam int SEL_BIT = 0;
  localparam int MASK_LSB = 1;
  localparam int MASK_MSB = 21;
  localparam int OUT_W = 21;
  localparam int BOOST_OUT_W = 19;
  // configuration word fields
  localparam int LVL_LSB = 1;
  localparam int LVL_W = 3;
  localparam int CAP_LSB = 4;
  localparam int CAP_W = 2;
  localparam int BYPASS_BIT = 6;
  localparam int SYNC_BIT = 7;
  localparam int LIMOFF_BIT = 8;
  // codes and reset values
  localparam logic [LVL_W-1:0] LVL_SHUTDOWN = 3'h0;
  localparam logic [CAP_W-1:0] CAP_SOFT = 2'h0;
  localparam logic [OUT_W-1:0] MASK_RESET = 21'h000000;
  localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;
  // soft start length in switch input cycles
  localparam int SOFT_CYCLES = 16384;
  // width of the bit counter that crosses from the link
  localparam int BITCNT_W = 8;
  localparam int PIN_W = 5;
  localparam int PIN_STROBE = 0;
  localparam int PIN_GATE = 1;
  localparam int PIN_SWITCH = 2;
  localparam int PIN_ABOVE = 3;
  localparam int PIN_OVER = 4;

  typedef struct packed {
    logic limitOff;
    logic syncRelease;
    logic rampBypass;
    logic [CAP_W-1:0] current_cap_code;
    logic [LVL_W-1:0] boost_level_code;
  } hvb_cfg_type;

  localparam hvb_cfg_type CFG_RESET = '{1'b0, 1'b0, 1'b0, 2'h0, 3'h0};

  typedef struct packed {
    logic [OUT_W-1:0] level;
    logic driveEnable;
  } hvb_hvout_type;

  typedef enum logic [1:0] {RAMP_OFF, RAMP_SOFT, RAMP_FULL} hvb_ramp_type;
endpackage

/* rtl/hvb_link_rx.sv */
// serial shift register on the link clock with a gray coded bit counter
`timescale 1ns/1ps
`default_nettype none
module hvb_link_rx
  import hvb_pkg::*;
(
  // link clock and reset request from the system side
  input wire logic serialClk,
  input wire logic rst,
  // serial pins
  input wire logic serialData,
  input wire logic load_strobe,
  // towards the system domain
  output logic [WORD_W-1:0] shiftWord,
  output logic [BITCNT_W-1:0] shiftCountGray
);
  logic rstMeta;
  logic linkRst;
  logic [BITCNT_W-1:0] shiftCount;
  logic [WORD_W-1:0] next_shiftWord;
  logic [BITCNT_W-1:0] next_shiftCount;

  always_comb
  begin
    next_shiftWord = shiftWord;
    next_shiftCount = shiftCount;
    if (linkRst)
    begin
      next_shiftWord = WORD_RESET;
      next_shiftCount = '0;
    end
    else if (!load_strobe)
    begin
      next_shiftWord = {shiftWord[WORD_W-2:0], serialData};
      next_shiftCount = shiftCount + 1'b1;
    end
  end

  // data taken on the falling link clock edge
  always_ff @(negedge serialClk)
  begin
    rstMeta <= rst;
    linkRst <= rstMeta;
    shiftWord <= next_shiftWord;
    shiftCount <= next_shiftCount;
    shiftCountGray <= next_shiftCount ^ (next_shiftCount >> 1);
  end
endmodule
`default_nettype wire

/* rtl/hvb_output_word_and_boost_ctrl.sv */
// serial loaded output mask and boost control for the hv level shifters
// Overview of operation
// - word bit 0 picks config or mask
// - mask bits 21..1 drive outputs 20..0
// - mask bits 23..22 read back zero
// - boost variant drives only 19 outputs
// - mask clears to zero on reset
// - 3-bit level code sets boost target
// - 2-bit cap code limits supply current
// - switch input drives internal switch gate
// - regulation follows latched level and cap
// - new config words take effect anytime
// - soft start 16384 switch cycles at 200mA
// - after soft start use latched cap
// - bypass bit skips soft start
// - lowered level while active enables discharge
// - raised level while active keeps discharge off
// - MSB first, shifted on falling clock
// - strobe rise latches, high ignores, fall clears
// - outputs low while gate input low
// - level zero shuts down, outputs float
`timescale 1ns/1ps
`default_nettype none
module hvb_output_word_and_boost_ctrl
  import hvb_pkg::*;
#(
  parameter int SOFT_CYCLE_COUNT = SOFT_CYCLES,
  parameter bit HAS_BOOST = 1'b1
)
(
  // system clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial link
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic load_strobe,
  // output gate and boost timing
  input wire logic outputGate,
  input wire logic switch_drive_input,
  // analog feedback
  input wire logic railAboveTarget,
  input wire logic currentOverCap,
  // level shifter outputs
  output logic [OUT_W-1:0] hvOutLevel,
  output logic hvOutDriveEnable,
  // boost controls
  output logic switchGate,
  output logic railDischarge,
  output logic [LVL_W-1:0] boost_level_code,
  output logic [CAP_W-1:0] current_cap_code,
  output logic softStartActive,
  // readback of the latched words
  output logic [WORD_W-1:0] output_mask_word,
  output logic [WORD_W-1:0] configWord
);
  localparam int SOFT_W = $clog2(SOFT_CYCLE_COUNT + 1);
  localparam logic [SOFT_W-1:0] SOFT_LAST = SOFT_W'(SOFT_CYCLE_COUNT - 1);
  localparam logic [BITCNT_W-1:0] FULL_BITS = BITCNT_W'(WORD_W);
  localparam int LIVE_W = HAS_BOOST ? BOOST_OUT_W : OUT_W;
  localparam logic [OUT_W-1:0] LIVE_MASK = ~({OUT_W{1'b1}} << LIVE_W);

  if (SOFT_CYCLE_COUNT < 1)
  begin : g_bad_soft
    $error("soft start count must be at least one");
  end

  // link side
  logic [WORD_W-1:0] shiftWord;
  logic [BITCNT_W-1:0] shiftCountGray;

  hvb_link_rx u_link_rx (
    .serialClk(serialClk),
    .rst(rst),
    .serialData(serialData),
    .load_strobe(load_strobe),
    .shiftWord(shiftWord),
    .shiftCountGray(shiftCountGray)
  );

  // pin synchronisers and gray counter crossing
  logic [PIN_W-1:0] pinMeta;
  logic [PIN_W-1:0] pinSync2;
  logic [PIN_W-1:0] pinSync3;
  logic [PIN_W-1:0] pinLevel;
  logic [PIN_W-1:0] next_pinLevel;
  logic [BITCNT_W-1:0] grayMeta;
  logic [BITCNT_W-1:0] graySync;
  logic [BITCNT_W-1:0] countBin;
  logic [PIN_W-1:0] pinLast;

  always_comb
  begin
    next_pinLevel = ((pinSync2 ~^ pinSync3) & pinSync2) | ((pinSync2 ^ pinSync3) & pinLevel);
    // reset tracks the pins so no false edge follows release
    if (rst)
      next_pinLevel = pinSync2;
  end

  always_ff @(posedge clk)
  begin
    pinMeta <= {currentOverCap, railAboveTarget, switch_drive_input, outputGate, load_strobe};
    pinSync2 <= pinMeta;
    pinSync3 <= pinSync2;
    pinLevel <= next_pinLevel;
    pinLast <= pinLevel;
    grayMeta <= shiftCountGray;
    graySync <= grayMeta;
  end

  always_comb
  begin
    countBin = '0;
    for (int i = 0; i < BITCNT_W; i++)
    begin
      countBin[i] = ^(graySync >> i);
    end
  end

  // edge events on filtered pins
  logic strobeRise;
  logic strobeFall;
  logic switchRise;
  logic gateLevel;
  logic railAbove;
  logic overCap;

  assign strobeRise = pinLevel[PIN_STROBE] & ~pinLast[PIN_STROBE];
  assign strobeFall = ~pinLevel[PIN_STROBE] & pinLast[PIN_STROBE];
  assign switchRise = pinLevel[PIN_SWITCH] & ~pinLast[PIN_SWITCH];
  assign gateLevel = pinLevel[PIN_GATE];
  assign railAbove = pinLevel[PIN_ABOVE];
  assign overCap = pinLevel[PIN_OVER];

  // word capture and latches
  logic [BITCNT_W-1:0] frameBase;
  logic [BITCNT_W-1:0] next_frameBase;
  logic [BITCNT_W-1:0] frameBits;
  logic [WORD_W-1:0] frameKeep;
  logic [WORD_W-1:0] frameWord;
  logic [OUT_W-1:0] maskLatch;
  logic [OUT_W-1:0] next_maskLatch;
  hvb_cfg_type cfg;
  hvb_cfg_type next_cfg;
  logic cfgLoad;

  always_comb
  begin
    frameBits = countBin - frameBase;
    if (frameBits >= FULL_BITS)
      frameKeep = {WORD_W{1'b1}};
    else
      frameKeep = ~({WORD_W{1'b1}} << frameBits);
    // bits shifted before the strobe fell are dropped
    frameWord = shiftWord & frameKeep;
    next_frameBase = frameBase;
    if (strobeFall)
      next_frameBase = countBin;
    next_maskLatch = maskLatch;
    next_cfg = cfg;
    cfgLoad = 1'b0;
    if (strobeRise)
    begin
      if (frameWord[SEL_BIT])
        next_maskLatch = frameWord[MASK_MSB:MASK_LSB];
      else
      begin
        cfgLoad = 1'b1;
        next_cfg.limitOff = frameWord[LIMOFF_BIT];
        next_cfg.syncRelease = frameWord[SYNC_BIT];
        next_cfg.rampBypass = frameWord[BYPASS_BIT];
        next_cfg.current_cap_code = frameWord[CAP_LSB+:CAP_W];
        next_cfg.boost_level_code = frameWord[LVL_LSB+:LVL_W];
      end
    end
    if (rst)
    begin
      next_frameBase = countBin;
      next_maskLatch = MASK_RESET;
      next_cfg = CFG_RESET;
      cfgLoad = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    frameBase <= next_frameBase;
    maskLatch <= next_maskLatch;
    cfg <= next_cfg;
  end

  // soft start sequencing
  hvb_ramp_type rampState;
  hvb_ramp_type next_rampState;
  logic [SOFT_W-1:0] softCount;
  logic [SOFT_W-1:0] next_softCount;
  logic boostOn;

  assign boostOn = cfg.boost_level_code != LVL_SHUTDOWN;

  always_comb
  begin
    next_rampState = rampState;
    next_softCount = softCount;
    case (rampState)
      RAMP_OFF:
      begin
        next_softCount = '0;
        if (boostOn)
          next_rampState = cfg.rampBypass ? RAMP_FULL : RAMP_SOFT;
      end
      RAMP_SOFT:
      begin
        if (cfg.rampBypass)
          next_rampState = RAMP_FULL;
        else if (switchRise)
        begin
          next_softCount = softCount + 1'b1;
          if (softCount == SOFT_LAST)
            next_rampState = RAMP_FULL;
        end
      end
      RAMP_FULL:
      begin
        next_softCount = '0;
      end
      default:
      begin
        next_rampState = RAMP_OFF;
        next_softCount = '0;
      end
    endcase
    if (!boostOn)
      next_rampState = RAMP_OFF;
    if (rst)
    begin
      next_rampState = RAMP_OFF;
      next_softCount = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    rampState <= next_rampState;
    softCount <= next_softCount;
  end

  // regulation, switch gate and discharge
  logic releaseHeld;
  logic next_releaseHeld;
  logic stopSwitch;
  logic next_switchGate;
  logic next_railDischarge;
  logic [CAP_W-1:0] next_capOut;

  always_comb
  begin
    next_releaseHeld = releaseHeld;
    if (!cfg.syncRelease)
      next_releaseHeld = railAbove;
    else if (switchRise)
      next_releaseHeld = railAbove;
    stopSwitch = releaseHeld | (overCap & ~cfg.limitOff) | railDischarge;
    next_switchGate = pinLevel[PIN_SWITCH] & boostOn & ~stopSwitch;
    if (next_rampState == RAMP_SOFT)
      next_capOut = CAP_SOFT;
    else
      next_capOut = cfg.current_cap_code;
    next_railDischarge = railDischarge;
    if (railDischarge && !railAbove)
      next_railDischarge = 1'b0;
    if (cfgLoad && boostOn)
    begin
      if (next_cfg.boost_level_code < cfg.boost_level_code)
        next_railDischarge = 1'b1;
      else if (next_cfg.boost_level_code > cfg.boost_level_code)
        next_railDischarge = 1'b0;
    end
    if (rst)
    begin
      next_releaseHeld = 1'b0;
      next_switchGate = 1'b0;
      next_railDischarge = 1'b0;
      next_capOut = CAP_SOFT;
    end
  end

  always_ff @(posedge clk)
  begin
    releaseHeld <= next_releaseHeld;
    switchGate <= next_switchGate;
    railDischarge <= next_railDischarge;
    current_cap_code <= next_capOut;
  end

  // level shifter drive and readback
  hvb_hvout_type hvOut;
  hvb_hvout_type next_hvOut;
  logic [WORD_W-1:0] next_maskView;
  logic [WORD_W-1:0] next_cfgView;

  always_comb
  begin
    next_hvOut.level = gateLevel ? (maskLatch & LIVE_MASK) : '0;
    next_hvOut.driveEnable = boostOn;
    next_maskView = {2'b00, maskLatch, 1'b1};
    next_cfgView = WORD_RESET;
    next_cfgView[LIMOFF_BIT] = cfg.limitOff;
    next_cfgView[SYNC_BIT] = cfg.syncRelease;
    next_cfgView[BYPASS_BIT] = cfg.rampBypass;
    next_cfgView[CAP_LSB+:CAP_W] = cfg.current_cap_code;
    next_cfgView[LVL_LSB+:LVL_W] = cfg.boost_level_code;
    if (rst)
    begin
      next_hvOut = '0;
      next_maskView = WORD_RESET;
      next_cfgView = WORD_RESET;
    end
  end

  always_ff @(posedge clk)
  begin
    hvOut <= next_hvOut;
    output_mask_word <= next_maskView;
    configWord <= next_cfgView;
    boost_level_code <= rst ? LVL_SHUTDOWN : cfg.boost_level_code;
    softStartActive <= rst ? 1'b0 : (next_rampState == RAMP_SOFT);
  end

  assign hvOutLevel = hvOut.level;
  assign hvOutDriveEnable = hvOut.driveEnable;
endmodule
`default_nettype wire

/* dv/hvb_ctrl_checker.sv */
// assertion checker for the output word and boost control
`timescale 1ns/1ps
`default_nettype none
module hvb_ctrl_checker
  import hvb_pkg::*;
(
  // clock, reset and pins
  input wire logic clk,
  input wire logic rst,
  input wire logic outputGate,
  input wire logic railAboveTarget,
  // observed outputs
  input wire logic [OUT_W-1:0] hvOutLevel,
  input wire logic hvOutDriveEnable,
  input wire logic switchGate,
  input wire logic railDischarge,
  input wire logic [LVL_W-1:0] boost_level_code,
  input wire logic [CAP_W-1:0] current_cap_code,
  input wire logic softStartActive,
  input wire logic [WORD_W-1:0] output_mask_word
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_gate_low;
    (!outputGate)[*6] |=> hvOutLevel == '0;
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("output high, gate low");
  property p_follow;
    (outputGate && boost_level_code != 3'h0 && $stable(output_mask_word))[*6]
      |-> hvOutLevel == {2'h0, output_mask_word[19:1]};
  endproperty
  a_follow: assert property (p_follow) else $error("output off mask");
  property p_top_zero;
    output_mask_word[23:22] == 2'h0 && hvOutLevel[20:19] == 2'h0;
  endproperty
  a_top_zero: assert property (p_top_zero) else $error("top bits set");
  property p_drive;
    ($stable(boost_level_code))[*2] |-> hvOutDriveEnable == (boost_level_code != 3'h0);
  endproperty
  a_drive: assert property (p_drive) else $error("drive enable wrong");
  property p_soft_cap;
    softStartActive |-> current_cap_code == CAP_SOFT;
  endproperty
  a_soft_cap: assert property (p_soft_cap) else $error("cap during soft start");
  property p_raise;
    $past(boost_level_code) != 3'h0 && boost_level_code > $past(boost_level_code)
      |-> ##2 !railDischarge;
  endproperty
  a_raise: assert property (p_raise) else $error("discharge on raise");
  property p_lower;
    boost_level_code < $past(boost_level_code) && railAboveTarget |-> ##[0:2] railDischarge;
  endproperty
  a_lower: assert property (p_lower) else $error("no discharge on lower");
  property p_gate_off;
    (boost_level_code == 3'h0)[*2] |-> !switchGate;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("switch in shutdown");
endmodule
bind hvb_output_word_and_boost_ctrl hvb_ctrl_checker chk_u (.clk, .rst, .outputGate,
  .railAboveTarget, .hvOutLevel, .hvOutDriveEnable, .switchGate, .railDischarge,
  .boost_level_code, .current_cap_code, .softStartActive, .output_mask_word);
`default_nettype wire

/* dv/hvb_host_model.sv */
// host model: serial link, load strobe and switch pwm
`timescale 1ns/1ps
`default_nettype none
module hvb_host_model
  import hvb_pkg::*;
(
  // serial link
  output logic serialClk,
  output logic serialData,
  output logic load_strobe,
  // boost timing
  output logic switch_drive_input
);
  logic pwmOn;
  initial
  begin
    serialClk = 1'b0;
    serialData = 1'b0;
    load_strobe = 1'b1;
    switch_drive_input = 1'b0;
    pwmOn = 1'b0;
  end
  // 70 percent duty, 80 ns period, edges clear of the clk sampling edge
  always
  begin
    #24 switch_drive_input = pwmOn;
    #56 switch_drive_input = 1'b0;
  end
  // clocks while deselected, data never meaningful
  task automatic pulse(input int n);
    repeat (n)
    begin
      serialData = ~serialData;
      #7.5 serialClk = 1'b1;
      #7.5 serialClk = 1'b0;
    end
  endtask
  // n bits msb first, then latch on strobe rise
  task automatic send(input logic [WORD_W-1:0] w, input int n);
    load_strobe = 1'b0;
    #60;
    for (int i = n - 1; i >= 0; i--)
    begin
      serialClk = 1'b1;
      serialData = w[i];
      #7.5 serialClk = 1'b0;
      #7.5;
    end
    serialData = ~serialData;
    #60 load_strobe = 1'b1;
    #100;
  endtask
endmodule
`default_nettype wire

/* dv/hvb_output_word_and_boost_ctrl_bench.sv */
// self-checking bench for the output word and boost control
`timescale 1ns/1ps
`default_nettype none
module hvb_output_word_and_boost_ctrl_bench
  import hvb_pkg::*;
;
  logic clk, rst, outputGate, railAboveTarget, currentOverCap;
  logic serialClk, serialData, load_strobe, switch_drive_input;
  logic hvOutDriveEnable, switchGate, railDischarge, softStartActive;
  logic [OUT_W-1:0] hvOutLevel;
  logic [LVL_W-1:0] boost_level_code;
  logic [CAP_W-1:0] current_cap_code;
  logic [WORD_W-1:0] output_mask_word, configWord;
  int err_total;
  int cmp_count;
  hvb_output_word_and_boost_ctrl #(.SOFT_CYCLE_COUNT(8), .HAS_BOOST(1'b1)) dut_u (.clk, .rst,
    .serialClk, .serialData, .load_strobe, .outputGate, .switch_drive_input,
    .railAboveTarget, .currentOverCap, .hvOutLevel, .hvOutDriveEnable, .switchGate,
    .railDischarge, .boost_level_code, .current_cap_code, .softStartActive,
    .output_mask_word, .configWord);
  hvb_host_model host_u (.serialClk, .serialData, .load_strobe, .switch_drive_input);
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string name, input logic [WORD_W-1:0] seen,
    input logic [WORD_W-1:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_mask();
    host_u.send(24'h000066, 24);
    tick(2);
    check("cfg", configWord, 24'h000066);
    check("level", 24'(boost_level_code), 24'h000003);
    check("cap", 24'(current_cap_code), 24'h000002);
    check("soft", 24'(softStartActive), 24'h000000);
    check("drv", 24'(hvOutDriveEnable), 24'h000001);
    outputGate = 1'b1;
    host_u.send(24'hffffff, 24);
    tick(2);
    check("mask", output_mask_word, 24'h3fffff);
    check("cfg", configWord, 24'h000066);
    check("out", 24'(hvOutLevel), 24'h07ffff);
    outputGate = 1'b0;
    tick(8);
    check("out", 24'(hvOutLevel), 24'h000000);
    outputGate = 1'b1;
    host_u.send(24'h000015, 5);
    tick(2);
    check("mask", output_mask_word, 24'h000015);
    check("out", 24'(hvOutLevel), 24'h00000a);
  endtask
  task automatic t_soft();
    int n;
    host_u.send(24'h000000, 24);
    check("drv", 24'(hvOutDriveEnable), 24'h000000);
    host_u.pwmOn = 1'b1;
    host_u.send(24'h000034, 24);
    check("soft", 24'(softStartActive), 24'h000001);
    check("cap", 24'(current_cap_code), 24'h000000);
    n = 0;
    while (softStartActive === 1'b1 && n < 400)
    begin
      tick(1);
      n++;
    end
    if (n == 400)
    begin
      err_total++;
      results();
    end
    check("soft_len", 24'(n > 10), 24'h000001);
    check("cap", 24'(current_cap_code), 24'h000003);
  endtask
  task automatic t_dis();
    int n;
    railAboveTarget = 1'b1;
    tick(8);
    host_u.send(24'h000072, 24);
    tick(1);
    check("dis", 24'(railDischarge), 24'h000001);
    check("gate", 24'(switchGate), 24'h000000);
    railAboveTarget = 1'b0;
    tick(8);
    check("dis", 24'(railDischarge), 24'h000000);
    n = 0;
    repeat (20)
    begin
      tick(1);
      n += int'(switchGate === 1'b1);
    end
    check("gate_runs", 24'(n > 0), 24'h000001);
    currentOverCap = 1'b1;
    tick(8);
    n = 0;
    repeat (20)
    begin
      tick(1);
      n += int'(switchGate === 1'b1);
    end
    check("gate_cap", 24'(n), 24'h000000);
    host_u.send(24'h000172, 24);
    n = 0;
    repeat (20)
    begin
      tick(1);
      n += int'(switchGate === 1'b1);
    end
    check("gate_nolim", 24'(n > 0), 24'h000001);
    currentOverCap = 1'b0;
    railAboveTarget = 1'b1;
    host_u.send(24'h000078, 24);
    tick(1);
    check("dis", 24'(railDischarge), 24'h000000);
    check("level", 24'(boost_level_code), 24'h000004);
  endtask
  initial
  begin
    err_total = 0;
    cmp_count = 0;
    rst = 1'b1;
    outputGate = 1'b0;
    railAboveTarget = 1'b0;
    currentOverCap = 1'b0;
    host_u.pulse(3);
    tick(4);
    rst = 1'b0;
    // link reset synchroniser needs falling link edges to release
    host_u.pulse(3);
    tick(4);
    check("mask", output_mask_word, 24'h000001);
    check("cfg", configWord, 24'h000000);
    check("drv", 24'(hvOutDriveEnable), 24'h000000);
    t_mask();
    t_soft();
    t_dis();
    results();
  end
endmodule
`default_nettype wire
